// >>> hdl/tsd_pkg.sv
// Constants, types and decode functions for the time-slot switch config core.
// Assumes one 40 MHz system clock; all users reference items as tsd_pkg::name.
`default_nettype none

package tsd_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADR_MODE = 8'h00;
	localparam logic [7:0] ADR_SKEW = 8'h04;
	localparam logic [7:0] ADR_PAIR = 8'h08;
	localparam logic [7:0] ADR_STAT = 8'h0c;
	localparam logic [7:0] ADR_SLOT = 8'h10;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int MODE_DMO_BIT = 0;
	localparam int MODE_SCB_LSB = 1;
	localparam int MODE_IDR_LSB = 3;
	localparam int MODE_ODR_LSB = 5;
	localparam int SKEW_AMT_LSB = 0;
	localparam int SKEW_EN_BIT = 3;
	localparam int PAIR_A_LSB = 0;
	localparam int PAIR_B_LSB = 4;
	localparam int STAT_IN_CNT_LSB = 0;
	localparam int STAT_OUT_CNT_LSB = 8;
	localparam int STAT_IN_RATE_LSB = 16;
	localparam int STAT_OUT_RATE_LSB = 18;
	localparam int STAT_VC_OK_BIT = 20;
	localparam int STAT_BLOCK_BIT = 21;
	localparam int STAT_ERR_BIT = 22;
	localparam int STAT_OFFS_BIT = 23;
	localparam int SLOT_IN_LSB = 0;
	localparam int SLOT_OUT_LSB = 8;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] SKEW_RST = 8'h00;
	localparam logic [7:0] PAIR_RST = 8'h32;

	// ****************************************
	// Timing constants
	// ****************************************
	localparam logic [7:0] SLOTS_2M = 8'h20;
	localparam logic [7:0] SLOTS_4M = 8'h40;
	localparam logic [7:0] SLOTS_8M = 8'h80;
	localparam logic [3:0] DMIN_2M = 4'h3;
	localparam logic [3:0] DMIN_4M = 4'h5;
	localparam logic [3:0] DMIN_8M = 4'h9;
	localparam logic [2:0] OFFS_MAX = 3'h4;
	localparam int OFFS_TAPS = 5;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int N_STREAM = 16;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M, RATE_RSVD} tsd_rate_t;

	typedef struct packed {
		logic [4:0] in_cnt;
		logic [4:0] out_cnt;
		logic [15:0] in_mask;
		logic [15:0] out_mask;
		tsd_rate_t in_rate;
		tsd_rate_t out_rate;
		logic vc_ok;
		logic blocking;
		logic err;
	} tsd_cfg_t;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [7:0] tsd_slots(input tsd_rate_t r);
		case (r)
			RATE_4M: tsd_slots = SLOTS_4M;
			RATE_8M: tsd_slots = SLOTS_8M;
			default: tsd_slots = SLOTS_2M;
		endcase
	endfunction : tsd_slots

	function automatic logic [3:0] tsd_dmin(input tsd_rate_t r);
		case (r)
			RATE_4M: tsd_dmin = DMIN_4M;
			RATE_8M: tsd_dmin = DMIN_8M;
			default: tsd_dmin = DMIN_2M;
		endcase
	endfunction : tsd_dmin

	// Mask of streams 0 .. cnt-1
	function automatic logic [15:0] tsd_first(input logic [4:0] cnt);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < N_STREAM; i++) begin
			if (5'(i) < cnt) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : tsd_first

endpackage : tsd_pkg

`default_nettype wire

// >>> hdl/tsd_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`default_nettype none

module tsd_buf #(
	parameter int W = 9
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);

	if (W < 1) begin : g_bad_w
		$error("tsd_buf width must be positive");
	end

	logic [W-1:0] d0_q, d0_d, d1_q, d1_d;
	logic [1:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready_o = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o = d0_q;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		d0_d = d0_q;
		d1_d = d1_q;
		cnt_d = cnt_q;
		if (pop) begin
			d0_d = d1_q;
			cnt_d = cnt_d - 2'h1;
		end
		if (push) begin
			if (cnt_d == 2'h0) begin
				d0_d = in_data_i;
			end else begin
				d1_d = in_data_i;
			end
			cnt_d = cnt_d + 2'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			d0_q <= '0;
			d1_q <= '0;
			cnt_q <= 2'h0;
		end else begin
			d0_q <= d0_d;
			d1_q <= d1_d;
			cnt_q <= cnt_d;
		end
	end

endmodule : tsd_buf

`default_nettype wire

// >>> hdl/tsd_core.sv
// Rate configuration, input skew and throughput delay core of a TDM switch.
// Assumes a classic Wishbone master on clk_i, serial pins asynchronous to clk_i
// and an interface clock far slower than clk_i so every edge is seen.
//
// The placing of the registers and register access over Wishbone were decided locally.
`default_nettype none

// Behaviour
// - 8 Mb/s identical rate: 2x2, ignore config bits
// - 8 Mb/s streams carry 128 slots per frame
// - Different rates: use input and output rate fields
// - Different rates: full switch, delay mode selectable
// - Stream counts set automatically from programmed rates
// - Input skew only at 4 or 8 Mb/s
// - Skew delays input sampling up to four clocks
// - Output frame stays on external frame pulse
// - Per-channel delay-mode bit, zero means variable
// - Variable delay depends only on channel numbers
// - Minimum variable delay three, five, nine slots
// - Beyond minimum, delay equals output minus input
// - Ten-pair config: four streams, 128x128 matrix
// - Main-operation bit picks identical or different rates
// - Constant delay: frame N read in N+2
module tsd_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial side pins
	input wire logic iface_clk_i,
	input wire logic frame_sync_input_i,
	input wire logic [15:0] serial_in_stream_i,
	// Timing outputs
	output logic virt_frame_o,
	output logic out_frame_o,
	output logic [15:0] in_bits_o,
	output logic [15:0] in_stream_en_o,
	output logic [15:0] out_stream_en_o,
	output logic [7:0] in_slot_o,
	output logic [7:0] out_slot_o,
	// Delay request
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [7:0] req_src_ch_i,
	input wire logic [7:0] req_dst_ch_i,
	input wire logic req_delay_mode_i,
	// Delay answer
	output logic rsp_valid_o,
	input wire logic rsp_ready_i,
	output logic [8:0] rsp_delay_o
);

	// ****************************************
	// Local functions
	// ****************************************
	function automatic logic [15:0] pair_bit(input logic [3:0] s);
		logic [15:0] m;
		m = 16'h0000;
		if (s >= 4'h2 && s <= 4'h9) begin
			m[s] = 1'b1;
		end
		return m;
	endfunction : pair_bit

	function automatic tsd_pkg::tsd_cfg_t decode(input logic rate_mode_select, input logic [1:0] config_select_bits,
			input tsd_pkg::tsd_rate_t ir, input tsd_pkg::tsd_rate_t orr,
			input logic [3:0] pa, input logic [3:0] pb);
		tsd_pkg::tsd_cfg_t c;
		logic [15:0] pmask;
		c = '0;
		pmask = 16'h0003 | pair_bit(pa) | pair_bit(pb);
		if (!rate_mode_select) begin
			c.in_rate = ir;
			c.out_rate = ir;
			case (ir)
				tsd_pkg::RATE_8M: begin
					c.in_cnt = 5'h02;
					c.out_cnt = 5'h02;
					c.vc_ok = 1'b1;
				end
				tsd_pkg::RATE_4M: begin
					c.in_cnt = (config_select_bits == 2'h0) ? 5'h08 : 5'h04;
					c.out_cnt = 5'h04;
					c.vc_ok = (config_select_bits != 2'h0);
					c.blocking = (config_select_bits == 2'h0);
				end
				tsd_pkg::RATE_2M: begin
					case (config_select_bits)
						2'h0: begin
							c.in_cnt = 5'h08;
							c.out_cnt = 5'h08;
							c.vc_ok = 1'b1;
						end
						2'h1: begin
							c.in_cnt = 5'h10;
							c.out_cnt = 5'h08;
							c.blocking = 1'b1;
						end
						2'h2: begin
							c.in_cnt = 5'h04;
							c.out_cnt = 5'h04;
							c.vc_ok = 1'b1;
						end
						default: begin
							c.in_cnt = 5'h08;
							c.out_cnt = 5'h04;
							c.blocking = 1'b1;
						end
					endcase
				end
				default: c.err = 1'b1;
			endcase
		end else begin
			c.in_rate = ir;
			c.out_rate = orr;
			c.vc_ok = 1'b1;
			if (ir == tsd_pkg::RATE_2M && orr == tsd_pkg::RATE_4M) begin
				c.in_cnt = 5'h08;
				c.out_cnt = 5'h04;
			end else if (ir == tsd_pkg::RATE_2M && orr == tsd_pkg::RATE_8M) begin
				c.in_cnt = 5'h08;
				c.out_cnt = 5'h02;
			end else if (ir == tsd_pkg::RATE_4M && orr == tsd_pkg::RATE_2M) begin
				c.in_cnt = 5'h04;
				c.out_cnt = 5'h08;
			end else if (ir == tsd_pkg::RATE_8M && orr == tsd_pkg::RATE_2M) begin
				c.in_cnt = 5'h02;
				c.out_cnt = 5'h08;
			end else begin
				c.err = 1'b1;
				c.vc_ok = 1'b0;
			end
		end
		c.in_mask = tsd_pkg::tsd_first(c.in_cnt);
		c.out_mask = tsd_pkg::tsd_first(c.out_cnt);
		if (!rate_mode_select && ir == tsd_pkg::RATE_2M && config_select_bits == 2'h2) begin
			c.in_mask = pmask;
			c.out_mask = pmask;
		end
		return c;
	endfunction : decode

	// Delay in slots of the given rate from channel numbers only
	function automatic logic [8:0] delay_of(input logic [7:0] n, input logic [7:0] m,
			input logic vc, input tsd_pkg::tsd_rate_t r);
		logic [7:0] sl;
		logic [9:0] ss, nn, mm, dd, d;
		sl = tsd_pkg::tsd_slots(r);
		ss = {2'h0, sl};
		nn = {2'h0, n & (sl - 8'h01)};
		mm = {2'h0, m & (sl - 8'h01)};
		dd = {6'h00, tsd_pkg::tsd_dmin(r)};
		if (vc) begin
			d = (ss << 1) + mm - nn - 10'h001;
		end else if (mm >= nn + dd) begin
			d = mm - nn;
		end else begin
			d = mm + ss - nn;
		end
		return d[8:0];
	endfunction : delay_of

	// ****************************************
	// Register file
	// ****************************************
	logic [7:0] mode_q, mode_d, skew_q, skew_d, pair_q, pair_d;
	logic [31:0] dat_q, dat_d;
	logic ack_q, ack_d;
	logic acc;
	tsd_pkg::tsd_cfg_t cfg;
	logic offs_act;
	logic [2:0] amt;
	logic [7:0] in_slot_q, in_slot_d, out_slot_q, out_slot_d;

	assign acc = wb_cyc_i && wb_stb_i && !ack_q;
	assign cfg = decode(mode_q[tsd_pkg::MODE_DMO_BIT],
		mode_q[tsd_pkg::MODE_SCB_LSB +: 2],
		tsd_pkg::tsd_rate_t'(mode_q[tsd_pkg::MODE_IDR_LSB +: 2]),
		tsd_pkg::tsd_rate_t'(mode_q[tsd_pkg::MODE_ODR_LSB +: 2]),
		pair_q[tsd_pkg::PAIR_A_LSB +: 4], pair_q[tsd_pkg::PAIR_B_LSB +: 4]);
	// Offset is honoured only at the higher input rates
	assign offs_act = skew_q[tsd_pkg::SKEW_EN_BIT] &&
		(cfg.in_rate == tsd_pkg::RATE_4M || cfg.in_rate == tsd_pkg::RATE_8M);
	// Out-of-range amounts saturate rather than wrap
	assign amt = (skew_q[tsd_pkg::SKEW_AMT_LSB +: 3] > tsd_pkg::OFFS_MAX) ?
		tsd_pkg::OFFS_MAX : skew_q[tsd_pkg::SKEW_AMT_LSB +: 3];

	always_comb begin
		mode_d = mode_q;
		skew_d = skew_q;
		pair_d = pair_q;
		dat_d = dat_q;
		ack_d = acc;
		if (acc && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				tsd_pkg::ADR_MODE: mode_d = wb_dat_i[7:0];
				tsd_pkg::ADR_SKEW: skew_d = {4'h0, wb_dat_i[3:0]};
				tsd_pkg::ADR_PAIR: pair_d = wb_dat_i[7:0];
				default: ;
			endcase
		end
		if (acc) begin
			dat_d = 32'h0000_0000;
			case (wb_adr_i)
				tsd_pkg::ADR_MODE: dat_d[7:0] = mode_q;
				tsd_pkg::ADR_SKEW: dat_d[7:0] = skew_q;
				tsd_pkg::ADR_PAIR: dat_d[7:0] = pair_q;
				tsd_pkg::ADR_STAT: begin
					dat_d[tsd_pkg::STAT_IN_CNT_LSB +: 5] = cfg.in_cnt;
					dat_d[tsd_pkg::STAT_OUT_CNT_LSB +: 5] = cfg.out_cnt;
					dat_d[tsd_pkg::STAT_IN_RATE_LSB +: 2] = cfg.in_rate;
					dat_d[tsd_pkg::STAT_OUT_RATE_LSB +: 2] = cfg.out_rate;
					dat_d[tsd_pkg::STAT_VC_OK_BIT] = cfg.vc_ok;
					dat_d[tsd_pkg::STAT_BLOCK_BIT] = cfg.blocking;
					dat_d[tsd_pkg::STAT_ERR_BIT] = cfg.err;
					dat_d[tsd_pkg::STAT_OFFS_BIT] = offs_act;
				end
				tsd_pkg::ADR_SLOT: begin
					dat_d[tsd_pkg::SLOT_IN_LSB +: 8] = in_slot_q;
					dat_d[tsd_pkg::SLOT_OUT_LSB +: 8] = out_slot_q;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= tsd_pkg::MODE_RST;
			skew_q <= tsd_pkg::SKEW_RST;
			pair_q <= tsd_pkg::PAIR_RST;
			dat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			skew_q <= skew_d;
			pair_q <= pair_d;
			dat_q <= dat_d;
			ack_q <= ack_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign in_stream_en_o = cfg.in_mask;
	assign out_stream_en_o = cfg.out_mask;

	// ****************************************
	// Pin synchronisers and skew line
	// ****************************************
	logic [17:0] s1_q, s2_q;
	logic prev_q, prev_d, edge_w;
	logic [16:0] line_q [tsd_pkg::OFFS_TAPS];
	logic [16:0] line_d [tsd_pkg::OFFS_TAPS];
	logic [16:0] tap;
	logic [15:0] bits_q, bits_d;
	logic vfr_q, vfr_d, ofr_q, ofr_d;
	logic [2:0] in_bit_q, in_bit_d, out_bit_q, out_bit_d;

	assign edge_w = s2_q[17] && !prev_q;
	assign tap = line_d[offs_act ? amt : 3'h0];

	always_comb begin
		prev_d = s2_q[17];
		for (int i = 0; i < tsd_pkg::OFFS_TAPS; i++) begin
			line_d[i] = line_q[i];
		end
		if (edge_w) begin
			line_d[0] = s2_q[16:0];
			for (int i = 1; i < tsd_pkg::OFFS_TAPS; i++) begin
				line_d[i] = line_q[i-1];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= 18'h00000;
			s2_q <= 18'h00000;
			prev_q <= 1'b0;
			for (int i = 0; i < tsd_pkg::OFFS_TAPS; i++) begin
				line_q[i] <= 17'h00000;
			end
		end else begin
			s1_q <= {iface_clk_i, frame_sync_input_i, serial_in_stream_i};
			s2_q <= s1_q;
			prev_q <= prev_d;
			for (int i = 0; i < tsd_pkg::OFFS_TAPS; i++) begin
				line_q[i] <= line_d[i];
			end
		end
	end

	// ****************************************
	// Frame and slot timing
	// ****************************************
	always_comb begin
		bits_d = bits_q;
		vfr_d = vfr_q;
		ofr_d = ofr_q;
		in_bit_d = in_bit_q;
		in_slot_d = in_slot_q;
		out_bit_d = out_bit_q;
		out_slot_d = out_slot_q;
		if (edge_w) begin
			bits_d = tap[15:0] & cfg.in_mask;
			vfr_d = tap[16];
			ofr_d = line_d[0][16];
			if (tap[16]) begin
				in_bit_d = 3'h0;
				in_slot_d = 8'h00;
			end else begin
				in_bit_d = in_bit_q + 3'h1;
				if (in_bit_q == tsd_pkg::BIT_LAST) begin
					in_slot_d = (in_slot_q == tsd_pkg::tsd_slots(cfg.in_rate) - 8'h01) ?
						8'h00 : in_slot_q + 8'h01;
				end
			end
			if (line_d[0][16]) begin
				out_bit_d = 3'h0;
				out_slot_d = 8'h00;
			end else begin
				out_bit_d = out_bit_q + 3'h1;
				if (out_bit_q == tsd_pkg::BIT_LAST) begin
					out_slot_d = (out_slot_q == tsd_pkg::tsd_slots(cfg.out_rate) - 8'h01) ?
						8'h00 : out_slot_q + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bits_q <= 16'h0000;
			vfr_q <= 1'b0;
			ofr_q <= 1'b0;
			in_bit_q <= 3'h0;
			in_slot_q <= 8'h00;
			out_bit_q <= 3'h0;
			out_slot_q <= 8'h00;
		end else begin
			bits_q <= bits_d;
			vfr_q <= vfr_d;
			ofr_q <= ofr_d;
			in_bit_q <= in_bit_d;
			in_slot_q <= in_slot_d;
			out_bit_q <= out_bit_d;
			out_slot_q <= out_slot_d;
		end
	end

	assign in_bits_o = bits_q;
	assign virt_frame_o = vfr_q;
	assign out_frame_o = ofr_q;
	assign in_slot_o = in_slot_q;
	assign out_slot_o = out_slot_q;

	// ****************************************
	// Throughput delay path
	// ****************************************
	// Constant mode is refused where the configuration cannot keep frame order
	logic vc_eff;
	tsd_pkg::tsd_rate_t d_rate;
	logic [8:0] d_val;

	assign vc_eff = req_delay_mode_i && cfg.vc_ok;
	assign d_rate = mode_q[tsd_pkg::MODE_DMO_BIT] ? cfg.out_rate : cfg.in_rate;
	assign d_val = delay_of(req_src_ch_i, req_dst_ch_i, vc_eff, d_rate);

	tsd_buf #(
		.W(9)
	) u_buf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(req_valid_i),
		.in_ready_o(req_ready_o),
		.in_data_i(d_val),
		.out_valid_o(rsp_valid_o),
		.out_ready_i(rsp_ready_i),
		.out_data_o(rsp_delay_o)
	);

endmodule : tsd_core

`default_nettype wire

// >>> test/tsd_core_checker.sv
// Assertion checker for tsd_core, bound to the core's ports.
// Assumes classic Wishbone writes that take effect at the edge raising ack.
`default_nettype none
module tsd_core_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// Timing
	input wire logic virt_frame_o,
	input wire logic out_frame_o,
	input wire logic [15:0] in_stream_en_o,
	input wire logic [15:0] out_stream_en_o,
	input wire logic [7:0] in_slot_o,
	// Delay queue
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	input wire logic rsp_ready_i,
	input wire logic [8:0] rsp_delay_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************
	// Shadow of mode and skew enable
	// ****************
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic skew_q;
	logic skew_d;
	logic wr;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	always_comb begin
		mode_d = (wr && wb_adr_i == tsd_pkg::ADR_MODE) ? wb_dat_i[7:0] : mode_q;
		skew_d = (wr && wb_adr_i == tsd_pkg::ADR_SKEW) ? wb_dat_i[3] : skew_q;
	end
	always_ff @(posedge clk_i) begin
		mode_q <= rst_i ? tsd_pkg::MODE_RST : mode_d;
		skew_q <= rst_i ? 1'b0 : skew_d;
	end
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence wb_take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_pulse_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	bus_answer_a: assert property (
		wb_take_s |=> ack_pulse_s) else $error("Bus answer missing or long");
	same_8m_a: assert property (
		!mode_q[0] && mode_q[4:3] == 2'h2 |-> in_stream_en_o == 16'h0003
		&& out_stream_en_o == 16'h0003) else $error("Wrong masks at 8M");
	diff_28_a: assert property (
		mode_q[0] && mode_q[4:3] == 2'h0 && mode_q[6:5] == 2'h2 |->
		in_stream_en_o == 16'h00ff && out_stream_en_o == 16'h0003) else $error("Wrong 2to8 masks");
	diff_82_a: assert property (
		mode_q[0] && mode_q[4:3] == 2'h2 && mode_q[6:5] == 2'h0 |->
		in_stream_en_o == 16'h0003 && out_stream_en_o == 16'h00ff) else $error("Wrong 8to2 masks");
	// Only checked while skew stays off: the pipe may hold old samples after a change
	skew_off_a: assert property (
		!skew_q |-> virt_frame_o == out_frame_o) else $error("Frame skewed while off");
	slot_wrap_a: assert property (
		mode_q[4:3] == 2'h2 && $past(in_slot_o) == 8'h7f && in_slot_o != 8'h7f
		|-> in_slot_o == 8'h00) else $error("Slot did not wrap at 128");
	rsp_next_a: assert property (
		req_valid_i && req_ready_o && !rsp_valid_o |=> rsp_valid_o) else $error("No answer");
	rsp_hold_a: assert property (
		rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_delay_o))
		else $error("Answer dropped while stalled");
endmodule : tsd_core_checker

bind tsd_core tsd_core_checker tsd_core_checker_i (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_ack_o, .virt_frame_o, .out_frame_o, .in_stream_en_o, .out_stream_en_o,
	.in_slot_o, .req_valid_i, .req_ready_o, .rsp_valid_o, .rsp_ready_i, .rsp_delay_o
);
`default_nettype wire

// >>> test/tsd_serial_model.sv
// Serial backbone model: free running interface clock, frame pulse, input bits.
// Assumes the core samples on interface clock rising edges, frame active high.
`default_nettype none
module tsd_serial_model #(
	parameter int HALF_NS = 75,
	parameter int FRAME_BITS = 1024
) (
	// Serial pins
	output logic iface_clk_o,
	output logic frame_o,
	output logic [15:0] data_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int bit_n = 0;
	logic [15:0] pat = 16'hace1;
	// Data and frame move on the falling edge so the rising edge sees them settled
	initial begin
		iface_clk_o = 1'b0;
		frame_o = 1'b1;
		data_o = 16'h0000;
		#7;
		forever begin
			#HALF_NS iface_clk_o = 1'b1;
			#HALF_NS iface_clk_o = 1'b0;
			bit_n = (bit_n + 1) % FRAME_BITS;
			frame_o = (bit_n == 0);
			pat = {pat[14:0], pat[15] ^ pat[13] ^ pat[12] ^ pat[10]};
			data_o = pat;
		end
	end
endmodule : tsd_serial_model
`default_nettype wire

// >>> test/tsd_core_tb_top.sv
// Self-checking bench for tsd_core: registers, stream masks, delays, input skew.
// Assumes the serial model drives the pins and the checker is bound to the core.
`default_nettype none
module tsd_core_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	wire logic iface_w, frame_w;
	wire logic [15:0] ser_w;
	logic virt_frame_o, out_frame_o, req_ready_o, rsp_valid_o;
	logic [15:0] in_bits_o, in_stream_en_o, out_stream_en_o;
	logic [7:0] in_slot_o, out_slot_o;
	logic req_valid_i = 1'b0, req_delay_mode_i = 1'b0, rsp_ready_i = 1'b0;
	logic [7:0] req_src_ch_i = 8'h00, req_dst_ch_i = 8'h00;
	logic [8:0] rsp_delay_o;
	logic [16:0] lfsr_q = 17'h12b99;
	logic [8:0] exp_q[$];
	int num_errors = 0, checks_done = 0, cycles = 0;
	int cir[8] = '{2, 2, 2, 2, 0, 0, 1, 2};
	int cor[8] = '{2, 2, 2, 2, 1, 2, 0, 0};
	int cic[8] = '{2, 2, 2, 2, 8, 8, 4, 2};
	int coc[8] = '{2, 2, 2, 2, 4, 2, 8, 8};
	logic [6:0] rmd[4] = '{7'h00, 7'h0a, 7'h08, 7'h10};
	int rn[4] = '{32, 64, 64, 128};
	int rdm[4] = '{3, 5, 5, 9};
	logic rvc[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	always #12.5 clk_i = ~clk_i;
	// ****************
	// Design and partner
	// ****************
	tsd_core tsd_core_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .iface_clk_i(iface_w),
		.frame_sync_input_i(frame_w), .serial_in_stream_i(ser_w), .virt_frame_o,
		.out_frame_o, .in_bits_o, .in_stream_en_o, .out_stream_en_o, .in_slot_o,
		.out_slot_o, .req_valid_i, .req_ready_o, .req_src_ch_i, .req_dst_ch_i,
		.req_delay_mode_i, .rsp_valid_o, .rsp_ready_i, .rsp_delay_o);
	tsd_serial_model tsd_serial_model_i (.iface_clk_o(iface_w), .frame_o(frame_w),
		.data_o(ser_w));
	// ****************
	// Helpers
	// ****************
	function automatic logic [8:0] exp_dly(input int n, input int m, input int nn,
		input int dm, input logic c);
		if (c) return 9'(2 * nn + m - n - 1);
		return (m >= n + dm) ? 9'(m - n) : 9'(m - n + nn);
	endfunction : exp_dly
	function automatic logic [31:0] exp_stat(input int ic, input int oc, input int ir,
		input int orr);
		return 32'(ic) | 32'(oc) << 8 | 32'(ir) << 16 | 32'(orr) << 18 | 32'h00100000;
	endfunction : exp_stat
	task automatic rnd;
		lfsr_q = {lfsr_q[15:0], lfsr_q[16] ^ lfsr_q[13]};
	endtask : rnd
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_dly(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t delay %0d expected %0d", $time, got, exp);
		end
	endtask : chk_dly
	// Leaving a task at the releasing edge guarantees one idle cycle before the next
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic send(input int n, input int m, input logic c, input int r);
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_src_ch_i <= 8'(n);
		req_dst_ch_i <= 8'(m);
		req_delay_mode_i <= c;
		exp_q.push_back(exp_dly(n, m, rn[r], rdm[r], c && rvc[r]));
		do @(posedge clk_i); while (req_ready_o !== 1'b1);
		req_valid_i <= 1'b0;
	endtask : send
	task automatic drain;
		@(posedge clk_i);
		rsp_ready_i <= 1'b1;
		while (exp_q.size() > 0) begin
			do @(posedge clk_i); while (rsp_valid_o !== 1'b1);
			chk_dly(rsp_delay_o, exp_q.pop_front());
		end
		rsp_ready_i <= 1'b0;
	endtask : drain
	task automatic results;
		if (num_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			$display("[FAIL] %0t timeout", $time);
			results();
		end
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		int n;
		int m;
		int k;
		int e;
		logic c;
		logic p;
		logic [6:0] md;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, tsd_pkg::ADR_SKEW, 32'h0);
		chk_reg(rd, 32'(tsd_pkg::SKEW_RST));
		wb(1'b1, tsd_pkg::ADR_SKEW, 32'h0);
		wb(1'b0, tsd_pkg::ADR_PAIR, 32'h0);
		chk_reg(rd, 32'(tsd_pkg::PAIR_RST));
		wb(1'b1, tsd_pkg::ADR_STAT, 32'hffffffff);
		wb(1'b1, 8'h14, 32'hffffffff);
		wb(1'b0, 8'h14, 32'h0);
		chk_reg(rd, 32'h0);
		wb(1'b0, tsd_pkg::ADR_STAT, 32'h0);
		chk_reg(rd, exp_stat(8, 8, 0, 0));
		for (int i = 0; i < 8; i++) begin
			rnd();
			md = {(i < 4) ? lfsr_q[1:0] : 2'(cor[i]), 2'(cir[i]), (i < 4) ? 2'(i) : lfsr_q[3:2], i > 3};
			wb(1'b1, tsd_pkg::ADR_MODE, 32'(md));
			wb(1'b0, tsd_pkg::ADR_STAT, 32'h0);
			chk_reg(rd, exp_stat(cic[i], coc[i], cir[i], cor[i]));
			chk_reg(32'(in_stream_en_o), (32'h1 << cic[i]) - 1);
			chk_reg(32'(out_stream_en_o), (32'h1 << coc[i]) - 1);
			chk_reg(32'(in_bits_o & ~in_stream_en_o), 32'h0);
		end
		wb(1'b1, tsd_pkg::ADR_PAIR, 32'h95);
		wb(1'b1, tsd_pkg::ADR_MODE, 32'h04);
		wb(1'b0, tsd_pkg::ADR_STAT, 32'h0);
		chk_reg(rd, exp_stat(4, 4, 0, 0));
		chk_reg(32'({in_stream_en_o, out_stream_en_o}), 32'h02230223);
		for (int r = 0; r < 4; r++) begin
			wb(1'b1, tsd_pkg::ADR_MODE, 32'(rmd[r]));
			for (int j = 0; j < 6; j++) begin
				rnd();
				n = (j < 2) ? 5 : (j == 2) ? 0 : (j == 3) ? rn[r] - 1 : int'(lfsr_q[7:0]) % rn[r];
				m = (j < 2) ? 4 + j + rdm[r] : (j == 2) ? rn[r] - 1 : (j == 3) ? 0 : int'(lfsr_q[15:8]) % rn[r];
				c = (j > 1) && (j < 4 || lfsr_q[16]);
				send(n, m, c, r);
				if (j % 2 == 1) begin
					@(negedge clk_i);
					chk_reg(32'(req_ready_o), 32'h0);
					drain();
				end
			end
		end
		// Skew is turned on last: the checker compares frames only while it is off
		rnd();
		k = 1 + int'(lfsr_q[1:0]);
		wb(1'b1, tsd_pkg::ADR_MODE, 32'h00);
		wb(1'b1, tsd_pkg::ADR_SKEW, 32'h8 | 32'(k));
		wb(1'b0, tsd_pkg::ADR_STAT, 32'h0);
		chk_reg(rd >> 23, 32'h0);
		wb(1'b1, tsd_pkg::ADR_MODE, 32'h10);
		wb(1'b0, tsd_pkg::ADR_STAT, 32'h0);
		chk_reg(rd >> 23, 32'h1);
		do @(negedge clk_i); while (out_frame_o !== 1'b0);
		do @(negedge clk_i); while (out_frame_o !== 1'b1);
		e = 0;
		p = iface_w;
		while (virt_frame_o !== 1'b1) begin
			@(negedge clk_i);
			e = e + int'(iface_w && !p);
			p = iface_w;
		end
		chk_reg(32'(e), 32'(k));
		results();
	end
endmodule : tsd_core_tb_top
`default_nettype wire
